/* File: hdl/elblf_pkg.sv */
// Shared constants, bit maps and carrier types for the enable latch bank
package elblf_pkg;

  localparam int ELBLF_BUS_W = 4;
  localparam int ELBLF_SYNC_STAGES = 2;
  localparam int ELBLF_NUM_DRV = 4;
  localparam int ELBLF_NUM_RX = 2;
  localparam int ELBLF_NUM_BIST = 4;

  // Latch contents after a clear
  localparam logic [3:0] ELBLF_OE_RST = 4'h0;
  localparam logic [3:0] ELBLF_RX_RST = 4'h0;
  localparam logic [3:0] ELBLF_BIST_RST = 4'hf;

  // Shared-bus bit that feeds each driver enable: a1, a2, b1, b2
  localparam int ELBLF_OE_MAP [ELBLF_NUM_DRV] = '{0, 1, 2, 3};
  // Shared-bus bit that feeds each receive channel power enable: a, b
  localparam int ELBLF_RX_MAP [ELBLF_NUM_RX] = '{0, 2};
  // Shared-bus bit that feeds each self-test select: tx a, tx b, rx a, rx b
  localparam int ELBLF_BIST_MAP [ELBLF_NUM_BIST] = '{0, 1, 2, 3};

  // Field positions of the pin-level input group
  localparam int ELBLF_PIN_W = 8;
  localparam int ELBLF_PIN_BUS = 0;
  localparam int ELBLF_PIN_OE = 4;
  localparam int ELBLF_PIN_RX = 5;
  localparam int ELBLF_PIN_BIST = 6;
  localparam int ELBLF_PIN_DRST = 7;

  // Analog receive conditions of one channel, each active high
  typedef struct packed {
    logic freq_bad;
    logic amp_low;
    logic density_low;
  } elblf_cond_t;

  localparam int ELBLF_COND_W = 3;

endpackage

/* File: hdl/elblf_sync.sv */
// Two-stage synchroniser, one generate lane per bit
`timescale 1ns/100ps
module elblf_sync
  import elblf_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic meta_r;
      logic hold_r;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          hold_r <= meta_r;
        end
      end
      assign sync_out[i] = hold_r;
    end
  endgenerate

endmodule

/* File: hdl/elblf_latch.sv */
// One strobe-gated enable latch with device-reset clear
`timescale 1ns/100ps
module elblf_latch
  import elblf_pkg::*;
#(
  parameter logic [3:0] RST_VAL = 4'h0,
  parameter bit CLR_ONLY_CLOSED = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic strobe,
  input wire logic [ELBLF_BUS_W-1:0] bus,
  input wire logic device_reset_n,
  output logic [ELBLF_BUS_W-1:0] latch_r
);

  logic clear;

  assign clear = !device_reset_n && (!CLR_ONLY_CLOSED || !strobe);

  // Clear wins over loading; while open the latch follows the bus,
  // after the strobe falls it keeps the last sampled pattern.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch_r <= RST_VAL;
    end else if (clear) begin
      latch_r <= RST_VAL;
    end else if (strobe) begin
      latch_r <= bus;
    end
  end

endmodule

/* File: hdl/elblf_top.sv */
// Enable latch bank for drivers, receive power and self-test, plus link fault outputs
//
// What this block does
// - While the output-enable strobe is high the driver enables follow the shared bus.
// - A driver enable bit at one turns its serial driver on and at zero powers it down.
// - On the fall of the output-enable strobe the last bus pattern is held until reopened or cleared by a low device reset.
// - A low device reset clears the output-enable latch so all drivers are off.
// - While the receive-power strobe is high the bus sets the receive power enables.
// - On the fall of the receive-power strobe the last bus pattern is kept.
// - A low device reset clears the receive power latch so both channels are off.
// - While the self-test strobe is high a zero bit selects self-test and a one normal data.
// - On the fall of the self-test strobe the last bus pattern is kept.
// - A low device reset while the self-test latch is closed turns self-test off everywhere.
// - Each link fault output is active low and is the OR of four receive conditions.
// - The other two conditions are low transition density and the channel powered off.
`timescale 1ns/100ps
module elblf_top
  import elblf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ELBLF_BUS_W-1:0] shared_enable_bus,
  input wire logic output_enable_latch_strobe,
  input wire logic rx_power_latch_strobe,
  input wire logic selftest_latch_strobe,
  input wire logic device_reset_n,
  input wire elblf_cond_t rx_cond_chan_a,
  input wire elblf_cond_t rx_cond_chan_b,
  output logic [ELBLF_NUM_DRV-1:0] serial_driver_out_en,
  output logic [ELBLF_NUM_RX-1:0] rx_chan_power_en,
  output logic [ELBLF_NUM_BIST-1:0] selftest_normal,
  output logic link_fault_n_chan_a,
  output logic link_fault_n_chan_b
);

  logic [ELBLF_PIN_W-1:0] pin_raw;
  logic [ELBLF_PIN_W-1:0] pin_s;
  logic [2*ELBLF_COND_W-1:0] cond_s;
  elblf_cond_t cond_a_s;
  elblf_cond_t cond_b_s;
  logic [ELBLF_BUS_W-1:0] bus_s;
  logic oe_stb_s;
  logic rx_stb_s;
  logic bist_stb_s;
  logic drst_n_s;
  logic [ELBLF_BUS_W-1:0] oe_latch;
  logic [ELBLF_BUS_W-1:0] rx_latch;
  logic [ELBLF_BUS_W-1:0] bist_latch;
  logic [ELBLF_NUM_RX-1:0] rx_en;
  logic fault_a_nxt;
  logic fault_b_nxt;

  assign pin_raw = {device_reset_n, selftest_latch_strobe, rx_power_latch_strobe,
                    output_enable_latch_strobe, shared_enable_bus};

  // All pins are asynchronous to ref_clk
  elblf_sync #(.W(ELBLF_PIN_W)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  elblf_sync #(.W(2*ELBLF_COND_W)) u_cond_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({rx_cond_chan_b, rx_cond_chan_a}),
    .sync_out(cond_s)
  );

  assign bus_s = pin_s[ELBLF_PIN_BUS +: ELBLF_BUS_W];
  assign oe_stb_s = pin_s[ELBLF_PIN_OE];
  assign rx_stb_s = pin_s[ELBLF_PIN_RX];
  assign bist_stb_s = pin_s[ELBLF_PIN_BIST];
  assign drst_n_s = pin_s[ELBLF_PIN_DRST];
  assign cond_a_s = cond_s[ELBLF_COND_W-1:0];
  assign cond_b_s = cond_s[2*ELBLF_COND_W-1:ELBLF_COND_W];

  elblf_latch #(.RST_VAL(ELBLF_OE_RST), .CLR_ONLY_CLOSED(1'b0)) u_oe_latch (
    .ref_clk(ref_clk),
    .rst(rst),
    .strobe(oe_stb_s),
    .bus(bus_s),
    .device_reset_n(drst_n_s),
    .latch_r(oe_latch)
  );

  elblf_latch #(.RST_VAL(ELBLF_RX_RST), .CLR_ONLY_CLOSED(1'b0)) u_rx_latch (
    .ref_clk(ref_clk),
    .rst(rst),
    .strobe(rx_stb_s),
    .bus(bus_s),
    .device_reset_n(drst_n_s),
    .latch_r(rx_latch)
  );

  elblf_latch #(.RST_VAL(ELBLF_BIST_RST), .CLR_ONLY_CLOSED(1'b1)) u_bist_latch (
    .ref_clk(ref_clk),
    .rst(rst),
    .strobe(bist_stb_s),
    .bus(bus_s),
    .device_reset_n(drst_n_s),
    .latch_r(bist_latch)
  );

  genvar i;
  generate
    // Fixed driver mapping; one means driver on
    for (i = 0; i < ELBLF_NUM_DRV; i++) begin : g_drv
      assign serial_driver_out_en[i] = oe_latch[ELBLF_OE_MAP[i]];
    end
    for (i = 0; i < ELBLF_NUM_RX; i++) begin : g_rx
      assign rx_en[i] = rx_latch[ELBLF_RX_MAP[i]];
    end
    // One selects normal data, zero selects self-test
    for (i = 0; i < ELBLF_NUM_BIST; i++) begin : g_bist
      assign selftest_normal[i] = bist_latch[ELBLF_BIST_MAP[i]];
    end
  endgenerate

  assign rx_chan_power_en = rx_en;

  // Any of the four conditions pulls the fault low
  always_comb begin
    fault_a_nxt = cond_a_s.freq_bad | cond_a_s.amp_low | cond_a_s.density_low | !rx_en[0];
    fault_b_nxt = cond_b_s.freq_bad | cond_b_s.amp_low | cond_b_s.density_low | !rx_en[1];
  end

  // Channels are off after reset, so the fault shows from the start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_fault_n_chan_a <= 1'b0;
      link_fault_n_chan_b <= 1'b0;
    end else begin
      link_fault_n_chan_a <= !fault_a_nxt;
      link_fault_n_chan_b <= !fault_b_nxt;
    end
  end

endmodule

/* File: tb/elblf_host.sv */
// Host-side model that loads the three enable latches
`timescale 1ns/100ps
module elblf_host
  import elblf_pkg::*;
(
  input wire logic ref_clk,
  output logic [ELBLF_BUS_W-1:0] bus,
  output logic [2:0] stb
);
  initial begin
    bus = 4'hf;
    stb = 3'h0;
  end
  task automatic load(input int k, input logic [3:0] p);
    @(posedge ref_clk) bus <= p;
    @(posedge ref_clk) stb[k] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    stb[k] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // Released bus floats to the pull-up level
    bus <= 4'hf;
    @(posedge ref_clk);
  endtask
endmodule

/* File: tb/elblf_top_properties.sv */
// Port-level assertions for the enable latch bank
`timescale 1ns/100ps
module elblf_top_properties
  import elblf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ELBLF_BUS_W-1:0] shared_enable_bus,
  input wire logic output_enable_latch_strobe,
  input wire logic rx_power_latch_strobe,
  input wire logic selftest_latch_strobe,
  input wire logic device_reset_n,
  input wire elblf_cond_t rx_cond_chan_a,
  input wire elblf_cond_t rx_cond_chan_b,
  input wire logic [ELBLF_NUM_DRV-1:0] serial_driver_out_en,
  input wire logic [ELBLF_NUM_RX-1:0] rx_chan_power_en,
  input wire logic [ELBLF_NUM_BIST-1:0] selftest_normal,
  input wire logic link_fault_n_chan_a,
  input wire logic link_fault_n_chan_b
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  drv_follow_a: assert property (
    (output_enable_latch_strobe && device_reset_n && $stable(shared_enable_bus)) [*4]
    |=> serial_driver_out_en == shared_enable_bus) else $error("driver enables off bus");
  drv_hold_a: assert property (
    (!output_enable_latch_strobe && device_reset_n) [*3] |=> $stable(serial_driver_out_en))
    else $error("driver enables moved");
  dev_clear_a: assert property (
    !device_reset_n [*3] |=> serial_driver_out_en == 4'h0 && rx_chan_power_en == 2'h0)
    else $error("device reset did not clear");
  rx_follow_a: assert property (
    (rx_power_latch_strobe && device_reset_n && $stable(shared_enable_bus)) [*4]
    |=> rx_chan_power_en == {shared_enable_bus[2], shared_enable_bus[0]})
    else $error("receive power off bus");
  bist_follow_a: assert property (
    (selftest_latch_strobe && device_reset_n && $stable(shared_enable_bus)) [*4]
    |=> selftest_normal == shared_enable_bus) else $error("self-test off bus");
  bist_clear_a: assert property (
    (!selftest_latch_strobe && !device_reset_n) [*3] |=> selftest_normal == 4'hf)
    else $error("self-test not cleared");
  fault_cond_a: assert property (
    (rx_cond_chan_a != 3'h0) [*4] |=> !link_fault_n_chan_a) else $error("fault a missed");
  fault_off_a: assert property (
    !rx_chan_power_en[1] [*2] |-> !link_fault_n_chan_b) else $error("fault b missed");
  fault_none_a: assert property (
    (rx_cond_chan_a == 3'h0 && rx_chan_power_en[0]) [*4] |=> link_fault_n_chan_a)
    else $error("false fault a");
endmodule
bind elblf_top elblf_top_properties chk (.*);

/* File: tb/elblf_top_tb_top.sv */
// Self-checking bench for the enable latch bank
`timescale 1ns/100ps
module elblf_top_tb_top;
  import elblf_pkg::*;
  logic ref_clk = 0, rst = 1, drst_n = 1;
  logic [3:0] bus, drv, st;
  logic [2:0] stb;
  logic [1:0] rx;
  elblf_cond_t ca = '0, cb = '0;
  logic lfa, lfb;
  int fails = 0, n_checks = 0;
  always #20 ref_clk = ~ref_clk;
  elblf_host host (.ref_clk(ref_clk), .bus(bus), .stb(stb));
  elblf_top dut (.ref_clk(ref_clk), .rst(rst), .shared_enable_bus(bus),
    .output_enable_latch_strobe(stb[0]), .rx_power_latch_strobe(stb[1]),
    .selftest_latch_strobe(stb[2]), .device_reset_n(drst_n), .rx_cond_chan_a(ca),
    .rx_cond_chan_b(cb), .serial_driver_out_en(drv), .rx_chan_power_en(rx),
    .selftest_normal(st), .link_fault_n_chan_a(lfa), .link_fault_n_chan_b(lfb));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each compare reads the output at the falling edge, where it has settled
  task automatic chk_drv(input logic [3:0] exp);
    @(negedge ref_clk);
    cmp({4'h0, drv}, {4'h0, exp});
  endtask
  task automatic chk_rx(input logic [1:0] exp);
    @(negedge ref_clk);
    cmp({6'h00, rx}, {6'h00, exp});
  endtask
  task automatic chk_st(input logic [3:0] exp);
    @(negedge ref_clk);
    cmp({4'h0, st}, {4'h0, exp});
  endtask
  task automatic chk_lf(input logic [1:0] exp);
    @(negedge ref_clk);
    cmp({6'h00, lfb, lfa}, {6'h00, exp});
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic t_oe;
    host.load(0, 4'ha);
    chk_drv(4'ha);
    repeat (5) @(posedge ref_clk);
    chk_drv(4'ha);
    host.load(0, 4'h5);
    chk_drv(4'h5);
    $display("t_oe done");
  endtask
  task automatic t_rx;
    host.load(1, 4'h4);
    chk_rx(2'h2);
    chk_lf(2'h2);
    host.load(1, 4'h5);
    chk_rx(2'h3);
    chk_lf(2'h3);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk) ca <= elblf_cond_t'(3'h1 << i);
      repeat (5) @(posedge ref_clk);
      chk_lf(2'h2);
    end
    @(posedge ref_clk) ca <= '0;
    repeat (5) @(posedge ref_clk);
    chk_lf(2'h3);
    // Channel b alone, so swapped condition inputs show up
    @(posedge ref_clk) cb <= elblf_cond_t'(3'h4);
    repeat (5) @(posedge ref_clk);
    chk_lf(2'h1);
    @(posedge ref_clk) cb <= '0;
    repeat (5) @(posedge ref_clk);
    chk_lf(2'h3);
    $display("t_rx done");
  endtask
  task automatic t_bist;
    host.load(2, 4'h6);
    chk_st(4'h6);
    @(posedge ref_clk) drst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk_st(4'hf);
    chk_drv(4'h0);
    chk_rx(2'h0);
    @(posedge ref_clk) drst_n <= 1'b1;
    // Device reset seen only while the self-test latch is open
    fork
      host.load(2, 4'h9);
      begin
        repeat (3) @(posedge ref_clk);
        drst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        drst_n <= 1'b1;
      end
    join
    chk_st(4'h9);
    chk_drv(4'h0);
    $display("t_bist done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_oe();
    t_rx();
    t_bist();
    end_of_test();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
endmodule
